// ===== cibw_top.sv
// card controller: identification commands, block write, register slave
// assumes an Avalon-MM master on i_ref_clk, cards on shared lines
`timescale 1ns/10ps
module cibw_top
   import cibw_pkg::*;
#(
   parameter int FIFO_DEPTH = 32,
   parameter int BLK_BYTES = BLOCK_BYTES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   output logic o_card_clock,
   input wire logic i_cmd,
   output logic o_cmd,
   output logic o_cmd_oe,
   input wire logic i_dat0,
   output logic o_dat0,
   output logic o_dat0_oe,
   output logic o_dma_request
);

   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int BLK_BITS = BLK_BYTES * 8;

   function automatic logic [6:0] crc7_of(input logic [39:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? CRC7_POLY : 7'h00);
      end
      return c;
   endfunction

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   logic acc_done;
   logic [1:0] ctrl;
   logic [7:0] clkdiv;
   logic [15:0] arg_low;
   logic [15:0] arg_high;
   cibw_cmd_t cmd_reg;
   cibw_fifoctl_t fifoctl;
   logic [ST0_W-1:0] st0;
   logic [ST0_W-1:0] st0_set;
   logic [31:0] rd_mux;
   logic [31:0] wr_val;
   logic wr_fire;
   logic rd_fire;
   logic fifo_full;
   logic stall;
   cibw_cstate_t cstate;
   cibw_dstate_t dstate;
   logic [135:0] rsp_frame;
   logic [127:0] rsp_view;
   cibw_rsp_t rsp_kind_q;
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] level;
   logic below;

   // a full FIFO stretches the data write rather than drop it
   assign stall = i_write & (i_address == OFF_TXDATA) & fifo_full;
   assign o_waitrequest = (i_read | i_write) & ~acc_done;
   assign wr_fire = i_write & acc_done;
   assign rd_fire = i_read & acc_done;
   assign wr_val = i_writedata & {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         acc_done <= 1'b0;
      end else begin
         acc_done <= (i_read | i_write) & ~acc_done & ~stall;
      end
   end

   // identifier in four words, short answers their argument
   assign rsp_view = (rsp_kind_q == CIBW_RSP_LONG) ? rsp_frame[128:1] : {96'h0, rsp_frame[39:8]};

   always_comb begin
      unique case (i_address)
         OFF_CTRL: rd_mux = {30'h0, ctrl};
         OFF_CLKDIV: rd_mux = {24'h0, clkdiv};
         OFF_ARG_LOW: rd_mux = {16'h0, arg_low};
         OFF_ARG_HIGH: rd_mux = {16'h0, arg_high};
         OFF_CMD: rd_mux = {23'h0, cmd_reg};
         OFF_ST0: rd_mux = {27'h0, st0};
         OFF_ST1: rd_mux = {16'h0, 8'(level), 5'h0, below, dstate != CIBW_D_IDLE, cstate != CIBW_C_IDLE};
         OFF_FIFOCTL: rd_mux = {27'h0, fifoctl, 1'b0};
         OFF_RSP0: rd_mux = rsp_view[31:0];
         OFF_RSP1: rd_mux = rsp_view[63:32];
         OFF_RSP2: rd_mux = rsp_view[95:64];
         OFF_RSP3: rd_mux = rsp_view[127:96];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_readdata <= 32'h0000_0000;
      end else if (!acc_done) begin
         o_readdata <= rd_mux;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl <= CTRL_RST;
         clkdiv <= CLKDIV_RST;
         arg_low <= 16'h0000;
         arg_high <= 16'h0000;
         cmd_reg <= '0;
         fifoctl <= '0;
      end else if (wr_fire) begin
         unique case (i_address)
            OFF_CTRL: ctrl <= wr_val[1:0];
            OFF_CLKDIV: clkdiv <= (wr_val[7:0] == 8'h00) ? 8'h01 : wr_val[7:0];
            OFF_ARG_LOW: arg_low <= wr_val[15:0];
            OFF_ARG_HIGH: arg_high <= wr_val[15:0];
            OFF_CMD: cmd_reg <= wr_val[8:0];
            OFF_FIFOCTL: fifoctl <= wr_val[4:1];
            default: ;
         endcase
      end
   end

   // clear only reported bits, so a same-cycle event survives
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st0 <= '0;
      end else if (rd_fire && i_address == OFF_ST0) begin
         st0 <= (st0 & ~o_readdata[ST0_W-1:0]) | st0_set;
      end else begin
         st0 <= st0 | st0_set;
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers and card clock divider
   // ------------------------------------------------------------
   logic [1:0] cmd_sync;
   logic [1:0] dat_sync;
   logic cmd_in;
   logic dat_in;
   logic [7:0] div_cnt;
   logic tick;
   logic clk_hold;
   logic rise_en;
   logic fall_en;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cmd_sync <= 2'h3;
         dat_sync <= 2'h3;
      end else begin
         cmd_sync <= {cmd_sync[0], i_cmd};
         dat_sync <= {dat_sync[0], i_dat0};
      end
   end
   assign cmd_in = cmd_sync[1];
   assign dat_in = dat_sync[1];

   assign tick = (div_cnt >= clkdiv);
   assign rise_en = tick & ~o_card_clock;
   // clock parks high while the FIFO is empty during the data-bit state
   assign fall_en = tick & o_card_clock & ~clk_hold;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_cnt <= 8'h00;
         o_card_clock <= 1'b0;
      end else if (tick) begin
         div_cnt <= 8'h00;
         if (rise_en || fall_en) begin
            o_card_clock <= ~o_card_clock;
         end
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // command engine
   // ------------------------------------------------------------
   logic [47:0] cmd_shift;
   logic [7:0] cbit_cnt;
   logic [2:0] wait_cnt;
   logic cmd_drive;
   logic cmd_start;
   logic trig_start;
   logic [7:0] rsp_last;
   logic ev_rsp;
   logic ev_tout;
   logic ev_bsy;

   assign cmd_start = wr_fire & (i_address == OFF_CMD) & ~wr_val[CMD_TRIGGER_BIT] & (cstate == CIBW_C_IDLE);
   assign trig_start = wr_fire & (i_address == OFF_CMD) & wr_val[CMD_TRIGGER_BIT];
   assign rsp_last = (rsp_kind_q == CIBW_RSP_LONG) ? 8'(LONG_RSP_BITS - 1) : 8'(CMD_BITS - 1);
   assign ev_tout = (cstate == CIBW_C_WAIT) & rise_en & cmd_in & (wait_cnt == 3'(RSP_WINDOW_CLKS - 1));
   assign ev_rsp = ((cstate == CIBW_C_RECV) & rise_en & (cbit_cnt == rsp_last))
                 | ((cstate == CIBW_C_SEND) & fall_en & (cbit_cnt == 8'(CMD_BITS)) & (rsp_kind_q == CIBW_RSP_NONE));
   assign ev_bsy = (cstate == CIBW_C_BUSY) & rise_en & dat_in;

   // open-drain mode only ever pulls low
   assign o_cmd_oe = cmd_drive & (~ctrl[CTRL_OPEN_DRAIN_BIT] | ~o_cmd);

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cstate <= CIBW_C_IDLE;
         cmd_shift <= 48'h0;
         cbit_cnt <= 8'h00;
         wait_cnt <= 3'h0;
         cmd_drive <= 1'b0;
         o_cmd <= 1'b1;
         rsp_frame <= 136'h0;
         rsp_kind_q <= CIBW_RSP_NONE;
      end else begin
         unique case (cstate)
            CIBW_C_IDLE: begin
               if (cmd_start) begin
                  cmd_shift <= {2'b01, wr_val[5:0], arg_high, arg_low,
                                crc7_of({2'b01, wr_val[5:0], arg_high, arg_low}), 1'b1};
                  rsp_kind_q <= cibw_rsp_t'(wr_val[7:6]);
                  cbit_cnt <= 8'h00;
                  cstate <= CIBW_C_SEND;
               end
            end
            CIBW_C_SEND: begin
               if (fall_en) begin
                  if (cbit_cnt == 8'(CMD_BITS)) begin
                     cmd_drive <= 1'b0;
                     o_cmd <= 1'b1;
                     wait_cnt <= 3'h0;
                     // no-response commands finish once the frame is out
                     cstate <= (rsp_kind_q == CIBW_RSP_NONE) ? CIBW_C_IDLE : CIBW_C_WAIT;
                  end else begin
                     cmd_drive <= 1'b1;
                     o_cmd <= cmd_shift[47];
                     cmd_shift <= {cmd_shift[46:0], 1'b0};
                     cbit_cnt <= cbit_cnt + 8'h01;
                  end
               end
            end
            CIBW_C_WAIT: begin
               if (rise_en) begin
                  if (!cmd_in) begin
                     rsp_frame <= 136'h0;
                     cbit_cnt <= 8'h01;
                     cstate <= CIBW_C_RECV;
                  end else if (ev_tout) begin
                     cstate <= CIBW_C_IDLE;
                  end else begin
                     wait_cnt <= wait_cnt + 3'h1;
                  end
               end
            end
            CIBW_C_RECV: begin
               if (rise_en) begin
                  rsp_frame <= {rsp_frame[134:0], cmd_in};
                  cbit_cnt <= cbit_cnt + 8'h01;
                  if (ev_rsp) begin
                     cstate <= (rsp_kind_q == CIBW_RSP_BUSY) ? CIBW_C_BUSY : CIBW_C_IDLE;
                  end
               end
            end
            CIBW_C_BUSY: begin
               if (ev_bsy) begin
                  cstate <= CIBW_C_IDLE;
               end
            end
            default: cstate <= CIBW_C_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // transmit FIFO
   // ------------------------------------------------------------
   logic [31:0] fifo_mem [FIFO_DEPTH];
   logic fifo_empty;
   logic push;
   logic pop;
   logic flush;
   logic [AW:0] thr_words;
   logic below_q;
   logic [11:0] dbit_cnt;

   assign level = wr_ptr - rd_ptr;
   assign fifo_full = (level == (AW+1)'(FIFO_DEPTH));
   assign fifo_empty = (level == '0);
   assign push = wr_fire & (i_address == OFF_TXDATA) & ~fifo_full;
   assign flush = wr_fire & (i_address == OFF_FIFOCTL) & wr_val[FIFO_FLUSH_BIT];
   assign pop = (dstate == CIBW_D_BITS) & fall_en & (dbit_cnt[4:0] == 5'h1F);
   assign thr_words = fifoctl.fifo_threshold_level_bit ? (AW+1)'(CHUNK_LARGE_BYTES / 4)
                                                        : (AW+1)'(CHUNK_SMALL_BYTES / 4);
   assign below = (dstate != CIBW_D_IDLE) & fifoctl.fifo_direction_bit & (level < thr_words);
   assign o_dma_request = below;
   assign clk_hold = (dstate == CIBW_D_BITS) & fifo_empty;

   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         fifo_mem[wr_ptr[AW-1:0]] <= wr_val;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         below_q <= 1'b0;
      end else begin
         below_q <= below;
         if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
         end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
         end
      end
   end

   // ------------------------------------------------------------
   // data-0 block transmitter
   // ------------------------------------------------------------
   logic [15:0] crc16;
   logic [3:0] gap_cnt;
   logic data_bit;
   logic ev_dat;

   // low byte first, msb first
   assign data_bit = fifo_mem[rd_ptr[AW-1:0]][{dbit_cnt[4:3], ~dbit_cnt[2:0]}];
   assign ev_dat = (dstate == CIBW_D_STATUS) & rise_en & (gap_cnt == 4'h0) & dat_in;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dstate <= CIBW_D_IDLE;
         dbit_cnt <= 12'h000;
         crc16 <= 16'h0000;
         gap_cnt <= 4'h0;
         o_dat0 <= 1'b1;
         o_dat0_oe <= 1'b0;
      end else begin
         unique case (dstate)
            CIBW_D_IDLE: begin
               if (trig_start && fifoctl.fifo_direction_bit) begin
                  dstate <= CIBW_D_START;
               end
            end
            CIBW_D_START: begin
               if (fall_en) begin
                  o_dat0 <= 1'b0;
                  o_dat0_oe <= 1'b1;
                  dbit_cnt <= 12'h000;
                  crc16 <= 16'h0000;
                  dstate <= CIBW_D_BITS;
               end
            end
            CIBW_D_BITS: begin
               if (fall_en) begin
                  o_dat0 <= data_bit;
                  crc16 <= {crc16[14:0], 1'b0} ^ ((data_bit ^ crc16[15]) ? CRC16_POLY : 16'h0000);
                  dbit_cnt <= dbit_cnt + 12'h001;
                  if (dbit_cnt == 12'(BLK_BITS - 1)) begin
                     dbit_cnt <= 12'h000;
                     dstate <= CIBW_D_CRC;
                  end
               end
            end
            CIBW_D_CRC: begin
               if (fall_en) begin
                  o_dat0 <= crc16[15];
                  crc16 <= {crc16[14:0], 1'b0};
                  dbit_cnt <= dbit_cnt + 12'h001;
                  if (dbit_cnt == 12'(CRC16_BITS - 1)) begin
                     dstate <= CIBW_D_END;
                  end
               end
            end
            CIBW_D_END: begin
               if (fall_en) begin
                  o_dat0 <= 1'b1;
                  gap_cnt <= 4'(WRITE_STATUS_GAP_CLKS);
                  dstate <= CIBW_D_STATUS;
               end
            end
            CIBW_D_STATUS: begin
               if (rise_en) begin
                  o_dat0_oe <= 1'b0;
                  if (gap_cnt != 4'h0) begin
                     gap_cnt <= gap_cnt - 4'h1;
                  end else if (ev_dat) begin
                     dstate <= CIBW_D_IDLE;
                  end
               end
            end
            default: dstate <= CIBW_D_IDLE;
         endcase
      end
   end

   always_comb begin
      st0_set = '0;
      st0_set[ST0_DATA_DONE] = ev_dat;
      st0_set[ST0_BUSY_DONE] = ev_bsy;
      st0_set[ST0_RSP_DONE] = ev_rsp;
      st0_set[ST0_RSP_TIMEOUT] = ev_tout;
      st0_set[ST0_TX_READY] = below & ~below_q;
   end

endmodule

// ===== cibw_pkg.sv
// constants, register map and carrier types of the card controller
// assumes a 200 MHz clock and byte addresses on the register bus
package cibw_pkg;

   // ------------------------------------------------------------
   // register map (byte offsets)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CLKDIV = 8'h04;
   localparam logic [7:0] OFF_ARG_LOW = 8'h08;
   localparam logic [7:0] OFF_ARG_HIGH = 8'h0C;
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam logic [7:0] OFF_ST0 = 8'h14;
   localparam logic [7:0] OFF_ST1 = 8'h18;
   localparam logic [7:0] OFF_FIFOCTL = 8'h1C;
   localparam logic [7:0] OFF_TXDATA = 8'h20;
   localparam logic [7:0] OFF_RSP0 = 8'h24;
   localparam logic [7:0] OFF_RSP1 = 8'h28;
   localparam logic [7:0] OFF_RSP2 = 8'h2C;
   localparam logic [7:0] OFF_RSP3 = 8'h30;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_SD_BIT = 0;
   localparam int CTRL_OPEN_DRAIN_BIT = 1;
   localparam int CMD_TRIGGER_BIT = 9;
   localparam int ST0_DATA_DONE = 0;
   localparam int ST0_BUSY_DONE = 1;
   localparam int ST0_RSP_DONE = 2;
   localparam int ST0_RSP_TIMEOUT = 3;
   localparam int ST0_TX_READY = 4;
   localparam int ST0_W = 5;
   localparam int FIFO_FLUSH_BIT = 0;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam int REF_HZ = 200_000_000;
   localparam int ID_CLK_HZ = 400_000;
   localparam logic [7:0] CLKDIV_RST = 8'(REF_HZ / (2 * ID_CLK_HZ) - 1);
   localparam logic [1:0] CTRL_RST = 2'h2;
   localparam int CMD_BITS = 48;
   localparam int LONG_RSP_BITS = 136;
   localparam int RSP_WINDOW_CLKS = 5;
   localparam int BLOCK_BYTES = 512;
   localparam int CHUNK_SMALL_BYTES = 32;
   localparam int CHUNK_LARGE_BYTES = 64;
   localparam int CRC16_BITS = 16;
   localparam int WRITE_STATUS_GAP_CLKS = 8;
   localparam logic [6:0] CRC7_POLY = 7'h09;
   localparam logic [15:0] CRC16_POLY = 16'h1021;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CIBW_RSP_NONE = 2'b00,
      CIBW_RSP_SHORT = 2'b01,
      CIBW_RSP_LONG = 2'b10,
      CIBW_RSP_BUSY = 2'b11
   } cibw_rsp_t;

   typedef struct packed {
      logic data_write;
      cibw_rsp_t rsp_kind;
      logic [5:0] index;
   } cibw_cmd_t;

   typedef struct packed {
      logic [1:0] access_width_field;
      logic fifo_threshold_level_bit;
      logic fifo_direction_bit;
   } cibw_fifoctl_t;

   typedef enum logic [2:0] {
      CIBW_C_IDLE = 3'b000,
      CIBW_C_SEND = 3'b001,
      CIBW_C_WAIT = 3'b010,
      CIBW_C_RECV = 3'b011,
      CIBW_C_BUSY = 3'b100
   } cibw_cstate_t;

   typedef enum logic [2:0] {
      CIBW_D_IDLE = 3'b000,
      CIBW_D_START = 3'b001,
      CIBW_D_BITS = 3'b010,
      CIBW_D_CRC = 3'b011,
      CIBW_D_END = 3'b100,
      CIBW_D_STATUS = 3'b101
   } cibw_dstate_t;

endpackage

// ===== cibw_props.sv
// port checks of the card controller
// assumes binding into cibw_top, writes with all byte lanes
`timescale 1ns/10ps
module cibw_props
   import cibw_pkg::*;
#(
   parameter int FIFO_DEPTH = 32,
   parameter int BLK_BYTES = BLOCK_BYTES
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   input wire logic o_card_clock,
   input wire logic i_cmd,
   input wire logic o_cmd,
   input wire logic o_cmd_oe,
   input wire logic o_dat0_oe,
   input wire logic o_dma_request
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic ack, st0_rd, od_mode, dir_tx, dd_seen, ck_q;
   logic [3:0] quiet;
   assign ack = (i_read | i_write) & !o_waitrequest;
   assign st0_rd = ack & i_read & (i_address == OFF_ST0);
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         od_mode <= 1'b1;
         dir_tx <= 1'b0;
      end else if (ack && i_write && i_address == OFF_CTRL) begin
         od_mode <= i_writedata[CTRL_OPEN_DRAIN_BIT];
      end else if (ack && i_write && i_address == OFF_FIFOCTL) begin
         dir_tx <= i_writedata[1];
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) dd_seen <= 1'b0;
      else if (st0_rd) dd_seen <= o_readdata[ST0_DATA_DONE];
      else if (ack && i_write && i_address == OFF_CMD) dd_seen <= 1'b0;
   end
   // card clock rises with the line idle high
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ck_q <= 1'b0;
         quiet <= 4'h0;
      end else begin
         ck_q <= o_card_clock;
         if (!i_cmd || o_cmd_oe) quiet <= 4'h0;
         else if (o_card_clock && !ck_q && quiet != 4'hF) quiet <= quiet + 4'h1;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   chk_od_drive: assert property (od_mode && o_cmd_oe |-> !o_cmd)
      else $error("open-drain line driven high");
   chk_bus_wait: assert property (($rose(i_read) || $rose(i_write)) && i_address != OFF_TXDATA
      |-> o_waitrequest ##1 !o_waitrequest) else $error("no one-wait answer");
   chk_trig_start: assert property (ack && i_write && i_address == OFF_CMD && i_writedata[CMD_TRIGGER_BIT] && dir_tx
      |-> ##[1:1000] o_dat0_oe) else $error("trigger started no transfer");
   chk_clear_read: assert property (st0_rd && dd_seen |-> !o_readdata[ST0_DATA_DONE])
      else $error("flag survived read");
   chk_done_after: assert property (st0_rd && o_readdata[ST0_DATA_DONE] |-> !o_dat0_oe)
      else $error("done while data driven");
   chk_rsp_silence: assert property (st0_rd && o_readdata[ST0_RSP_TIMEOUT] |-> quiet >= 4'h5)
      else $error("early time-out");
   chk_dma_dir: assert property (o_dma_request |-> dir_tx)
      else $error("request without transmit");
   chk_unmapped: assert property (ack && i_read && i_address > OFF_RSP3 |-> o_readdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (st0_rd && o_readdata[ST0_DATA_DONE]);
   cover property (st0_rd && o_readdata[ST0_RSP_TIMEOUT]);
   cover property ($rose(o_dma_request));
endmodule

bind cibw_top cibw_props #(.FIFO_DEPTH(FIFO_DEPTH), .BLK_BYTES(BLK_BYTES)) u_props (.i_ref_clk, .i_reset_n,
   .i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .o_card_clock, .i_cmd, .o_cmd,
   .o_cmd_oe, .o_dat0_oe, .o_dma_request);

// ===== cibw_card_model.sv
// behavioural cards on the command line and data line 0
// assumes bench pull-ups; busy pulls data line 0 low
`timescale 1ns/10ps
module cibw_card_model #(
   parameter int N_CARDS = 2,
   parameter logic [127:0] CID_BASE = 128'h0
) (
   input wire logic i_clk,
   input wire logic i_cmd,
   input wire logic i_dat0_oe,
   input wire logic [1:0] i_gap,
   output logic o_cmd,
   output logic o_cmd_oe,
   output logic o_busy
);
   logic [47:0] rx;
   logic [135:0] tx;
   logic pp;
   int left;
   task automatic send(input int n);
      repeat (i_gap + 1) @(negedge i_clk);
      for (int k = n - 1; k >= 0; k--) begin
         o_cmd = tx[k];
         o_cmd_oe = pp | !tx[k];
         @(negedge i_clk);
      end
      o_cmd_oe = 1'b0;
   endtask
   task automatic busy();
      o_busy = 1'b1;
      #300;
      o_busy = 1'b0;
   endtask
   always @(negedge i_dat0_oe) busy();
   initial begin
      o_cmd = 1'b1;
      o_cmd_oe = 1'b0;
      o_busy = 1'b0;
      pp = 1'b0;
      left = N_CARDS;
      forever begin
         @(posedge i_clk);
         if (i_cmd === 1'b0 && !o_cmd_oe) begin
            rx = 48'h0;
            repeat (47) begin
               @(posedge i_clk);
               rx = {rx[46:0], i_cmd};
            end
            case (rx[45:40])
               6'd0: begin
                  left = N_CARDS;
                  pp = 1'b0;
               end
               6'd2: if (left > 0) begin
                  pp = 1'b0;
                  tx = {7'h1F, CID_BASE + 128'(left), 1'b1};
                  send(136);
               end
               6'd3: begin
                  tx[47:0] = {8'h03, 16'h1000 + left[15:0], 16'h0, 8'h01};
                  send(48);
                  pp = 1'b1;
                  left--;
               end
               default: begin
                  tx[47:0] = {2'b00, rx[45:40], rx[39:8], 8'h01};
                  send(48);
                  if (rx[45:40] == 6'd7) busy();
               end
            endcase
         end
      end
   end
endmodule

// ===== cibw_tb.sv
// testbench: two-card identification, block writes at both fifo thresholds
// assumes the card model as far side and pull-ups on both lines
`timescale 1ns/10ps
module testbench;
   import cibw_pkg::*;
   localparam int BLK = 512;
   localparam logic [127:0] CID = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978; // arbitrary value
   logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic [31:0] i_writedata = 32'h0, o_readdata, q, st, e;
   logic [1:0] gap = 2'h0;
   logic o_cmd, o_cmd_oe, o_dat0, o_dat0_oe, o_card_clock, o_waitrequest, o_dma_request, m_cmd, m_oe, m_busy;
   wire cmd_line = (o_cmd_oe ? o_cmd : 1'b1) & (m_oe ? m_cmd : 1'b1);
   wire dat_line = (o_dat0_oe ? o_dat0 : 1'b1) & !m_busy;
   int n_errors = 0, n_checks = 0, seed = 32'h3403DFAD;
   logic wire_bits[$];
   logic [31:0] words[$];
   cibw_top #(.FIFO_DEPTH(32), .BLK_BYTES(BLK)) dut (.i_ref_clk, .i_reset_n, .i_address, .i_read, .i_write,
      .i_writedata, .i_byteenable(4'hF), .o_readdata, .o_waitrequest, .o_card_clock, .i_cmd(cmd_line), .o_cmd,
      .o_cmd_oe, .i_dat0(dat_line), .o_dat0, .o_dat0_oe, .o_dma_request);
   cibw_card_model #(.N_CARDS(2), .CID_BASE(CID)) card (.i_clk(o_card_clock), .i_cmd(cmd_line),
      .i_dat0_oe(o_dat0_oe), .i_gap(gap), .o_cmd(m_cmd), .o_cmd_oe(m_oe), .o_busy(m_busy));
   initial forever #2.5 i_ref_clk = !i_ref_clk;
   always @(posedge o_card_clock) if (o_dat0_oe) wire_bits.push_back(o_dat0);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic stop_test();
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      i_address <= a;
      i_writedata <= d;
      i_write <= wr;
      i_read <= !wr;
      do @(posedge i_ref_clk); while (o_waitrequest !== 1'b0);
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic cmd(input logic [8:0] c, input logic [31:0] arg, input logic [31:0] m);
      gap <= 2'($random(seed));
      bus(1'b1, OFF_ARG_HIGH, {16'h0, arg[31:16]});
      bus(1'b1, OFF_ARG_LOW, {16'h0, arg[15:0]});
      bus(1'b1, OFF_CMD, {23'h0, c});
      poll(m);
   endtask
   task automatic poll(input logic [31:0] m);
      st = 32'h0;
      while ((st & m) == 32'h0) begin
         bus(1'b0, OFF_ST0, 32'h0);
         st = st | q;
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(posedge i_ref_clk);
      bus(1'b0, OFF_CLKDIV, 32'h0);
      chk("clkdiv reset", {24'h0, CLKDIV_RST}, q);
      bus(1'b0, OFF_CTRL, 32'h0);
      chk("ctrl reset", {30'h0, CTRL_RST}, q);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, OFF_CLKDIV, 32'h3); // fast card clock only to keep the run short
      cmd({1'b0, CIBW_RSP_NONE, 6'd0}, 32'h0, 32'h4);
      chk("go idle status", 32'h4, st);
      bus(1'b1, OFF_CTRL, 32'h3);
      for (int k = 0; k < 2; k++) begin
         cmd({1'b0, CIBW_RSP_SHORT, k ? 6'd41 : 6'd55}, 32'h00FF8000, 32'h4);
         bus(1'b0, OFF_RSP0, 32'h0);
         chk("app response", 32'h00FF8000, q);
      end
      for (int i = 0; i < 3; i++) begin
         cmd({1'b0, CIBW_RSP_LONG, 6'd2}, 32'h0, 32'hC);
         chk("cid status", i < 2 ? 32'h4 : 32'h8, st);
         for (int w = 0; w < 4 && i < 2; w++) begin
            bus(1'b0, OFF_RSP0 + 8'(4 * w), 32'h0);
            chk("cid word", 32'((CID + 128'(2 - i)) >> (32 * w)), q);
         end
         if (i < 2) begin
            cmd({1'b0, CIBW_RSP_SHORT, 6'd3}, 32'h0, 32'h4);
            bus(1'b0, OFF_RSP0, 32'h0);
            chk("relative address", {16'h1000 + 16'(2 - i), 16'h0}, q);
         end
      end
      bus(1'b1, OFF_CTRL, 32'h0);
      cmd({1'b0, CIBW_RSP_BUSY, 6'd7}, 32'h10010000, 32'h2);
      chk("select status", 32'h6, st);
      for (int th = 0; th < 2; th++) begin
         bus(1'b1, OFF_FIFOCTL, 32'h1);
         bus(1'b1, OFF_FIFOCTL, 32'(2 + 4 * th));
         words = {};
         repeat (BLK / 4) words.push_back($random(seed));
         for (int w = 0; w < 8; w++) bus(1'b1, OFF_TXDATA, words[w]);
         bus(1'b0, OFF_ST1, 32'h0);
         chk("fifo level", {16'h0, 8'h08, 8'h00}, q);
         cmd({1'b1, CIBW_RSP_SHORT, 6'd24}, 32'(th * BLK), 32'h4);
         wire_bits = {};
         bus(1'b1, OFF_CMD, 32'h200);
         for (int n = 0; n < 4000 && o_dma_request !== 1'b1; n++) @(posedge i_ref_clk);
         chk("dma request", 32'h1, {31'h0, o_dma_request});
         for (int w = 8; w < BLK / 4; w++) bus(1'b1, OFF_TXDATA, words[w]);
         poll(32'h1);
         chk("data done and ready", 32'h11, st & 32'h11);
         bus(1'b0, OFF_ST0, 32'h0);
         chk("status cleared", 32'h0, q);
         for (int b = 0; b <= BLK * 8; b++) begin
            e = b == 0 ? 32'h0 : 32'(words[(b - 1) / 32][8 * (((b - 1) % 32) / 8) + 7 - (b - 1) % 8]);
            chk("data bit", e, 32'(wire_bits[b]));
         end
      end
      stop_test();
   end
   initial begin
      #480_000;
      n_errors++;
      stop_test();
   end
endmodule
